// ---- dac_word_loader_cfg.svh ----
// Constants for the serial converter word loader
`ifndef DAC_WORD_LOADER_CFG_SVH
`define DAC_WORD_LOADER_CFG_SVH
`define WORD_BITS 16
`define CODE_BITS 10
`define MODE_MSB 13
`define MODE_LSB 12
`define CODE_MSB 11
`define CODE_LSB 2
`define CODE_RESET 10'h000
`define CODE_ZERO_SCALE 10'h000
`define CODE_FULL_SCALE 10'h3ff
`define MODE_RESET 2'h0
`define CLK_PERIOD_PS 5000
`define SEL_HIGH_MIN_PS 33000
`define SEL_HIGH_MIN_CYC ((`SEL_HIGH_MIN_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`endif

// ---- dac_word_loader_pkg.sv ----
// Types for the serial converter word loader
`default_nettype none
package dac_word_loader_pkg;
    typedef enum logic [1:0] {
        MODE_NORMAL = 2'h0,
        MODE_PULL_1K = 2'h1,
        MODE_PULL_100K = 2'h2,
        MODE_HIGH_Z = 2'h3
    } out_mode_e;
    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_SHIFT = 3'h2,
        ST_DONE = 3'h4
    } frame_state_e;
endpackage : dac_word_loader_pkg
`default_nettype wire

// ---- pin_sync.sv ----
// Two-flop synchroniser with edge detection for the serial pins
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
    parameter int WIDTH = 3,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input wire logic clk_sys_i,
    input wire logic arst_n_i,
    input wire logic [WIDTH-1:0] pin_i,
    output logic [WIDTH-1:0] level_o,
    output logic [WIDTH-1:0] rise_o,
    output logic [WIDTH-1:0] fall_o
);
    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] sync_reg;
    logic [WIDTH-1:0] prev_reg;

    // Synchroniser stages and history per bit
    genvar gi;
    generate
        for (gi = 0; gi < WIDTH; gi++) begin : g_bit
            always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
                if (!arst_n_i) begin
                    meta_reg[gi] <= RESET_VAL[gi];
                    sync_reg[gi] <= RESET_VAL[gi];
                    prev_reg[gi] <= RESET_VAL[gi];
                end else begin
                    meta_reg[gi] <= pin_i[gi];
                    sync_reg[gi] <= meta_reg[gi];
                    prev_reg[gi] <= sync_reg[gi];
                end
            end
        end
    endgenerate

    // Edges seen between the second stage and its history
    assign level_o = sync_reg;
    assign rise_o = sync_reg & ~prev_reg;
    assign fall_o = ~sync_reg & prev_reg;
endmodule : pin_sync
`default_nettype wire

// ---- serial_dac_word_loader.sv ----
// Serial word receiver loading converter code and output mode
// Contract
// - Sixteen-bit input shift register from data pin
// - Data sampled on falling shift-clock edges
// - Frame select active low, level enables shifting
// - Code and mode update at sixteenth edge
// - Early frame-select rise aborts, nothing changes
// - Code is unsigned straight binary, 0..1023
// - Code 000 zero scale, 3FF full scale
// - Word: two ignored, mode, ten data, two
// - Mode bits select normal, pulldowns, high-Z
// - Reset clears code; output held at zero
`timescale 1ns/1ps
`default_nettype none
`include "dac_word_loader_cfg.svh"
module serial_dac_word_loader #(
    parameter int WORD_BITS = `WORD_BITS,
    parameter int CODE_BITS = `CODE_BITS
) (
    input wire logic clk_sys_i,
    input wire logic arst_n_i,
    input wire logic frame_sel_n_i,
    input wire logic shift_clk_i,
    input wire logic serial_data_i,
    output logic [CODE_BITS-1:0] dac_code_o,
    output logic [1:0] out_mode_o,
    output logic mode_bit_high_o,
    output logic mode_bit_low_o,
    output logic powered_down_o,
    output logic load_pulse_o,
    output logic abort_pulse_o,
    output logic code_zero_scale_o,
    output logic code_full_scale_o
);
    localparam int CNT_W = $clog2(WORD_BITS + 1);
    localparam logic [CNT_W-1:0] LAST_BIT = CNT_W'(WORD_BITS - 1);

    dac_word_loader_pkg::frame_state_e state_reg;
    dac_word_loader_pkg::frame_state_e state_next;
    logic [WORD_BITS-1:0] shift_reg;
    logic [CNT_W-1:0] count_reg;
    logic [2:0] level_w;
    logic [2:0] rise_w;
    logic [2:0] fall_w;
    logic sel_low_w;
    logic sel_rise_w;
    logic sel_fall_w;
    logic sclk_fall_w;
    logic din_w;
    logic bit_take_w;
    logic word_done_w;
    logic [WORD_BITS-1:0] word_w;
    logic [CODE_BITS-1:0] code_word_w;
    logic [1:0] mode_word_w;

    // Converter field of an assembled word
    function automatic logic [CODE_BITS-1:0] code_field(
        input logic [WORD_BITS-1:0] word_in
    );
        return word_in[`CODE_MSB:`CODE_LSB];
    endfunction : code_field

    // Mode field of an assembled word
    function automatic logic [1:0] mode_field(
        input logic [WORD_BITS-1:0] word_in
    );
        return word_in[`MODE_MSB:`MODE_LSB];
    endfunction : mode_field

    // True while the frame machine accepts bits
    function automatic logic is_shifting(
        input dac_word_loader_pkg::frame_state_e st
    );
        return st == dac_word_loader_pkg::ST_SHIFT;
    endfunction : is_shifting

    // True for any of the three power-down modes
    function automatic logic is_powered_down(input logic [1:0] mode);
        return mode != 2'(dac_word_loader_pkg::MODE_NORMAL);
    endfunction : is_powered_down

    // Pins are asynchronous to the system clock; select idles high
    pin_sync #(
        .WIDTH(3),
        .RESET_VAL(3'h1)
    ) u_pin_sync (
        .clk_sys_i(clk_sys_i),
        .arst_n_i(arst_n_i),
        .pin_i({serial_data_i, shift_clk_i, frame_sel_n_i}),
        .level_o(level_w),
        .rise_o(rise_w),
        .fall_o(fall_w)
    );

    // Frame and clock events from synchronised pins
    assign sel_low_w = ~level_w[0];
    assign sel_rise_w = rise_w[0];
    assign sel_fall_w = fall_w[0];
    assign sclk_fall_w = fall_w[1];
    assign din_w = level_w[2];

    // A bit is taken only on a falling clock inside a live frame
    assign bit_take_w = is_shifting(state_reg)
        && sel_low_w && sclk_fall_w;
    assign word_done_w = bit_take_w && (count_reg == LAST_BIT);
    assign word_w = {shift_reg[WORD_BITS-2:0], din_w};

    // Frame sequencing
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            dac_word_loader_pkg::ST_IDLE: begin
                if (sel_fall_w) begin
                    state_next = dac_word_loader_pkg::ST_SHIFT;
                end
            end
            dac_word_loader_pkg::ST_SHIFT: begin
                if (!sel_low_w) begin
                    state_next = dac_word_loader_pkg::ST_IDLE;
                end else if (word_done_w) begin
                    state_next = dac_word_loader_pkg::ST_DONE;
                end
            end
            dac_word_loader_pkg::ST_DONE: begin
                if (!sel_low_w) begin
                    state_next = dac_word_loader_pkg::ST_IDLE;
                end
            end
            default: state_next = dac_word_loader_pkg::ST_IDLE;
        endcase
    end

    // State register
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_reg <= dac_word_loader_pkg::ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // Shift register and bit count, cleared at each frame start
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            shift_reg <= '0;
            count_reg <= '0;
        end else if (!is_shifting(state_reg) || !sel_low_w) begin
            shift_reg <= '0;
            count_reg <= '0;
        end else if (bit_take_w) begin
            shift_reg <= word_w;
            count_reg <= count_reg + CNT_W'(1);
        end
    end

    // Fields of the word that completes on this cycle
    assign code_word_w = code_field(word_w);
    assign mode_word_w = mode_field(word_w);

    // Converter code, cleared at reset, kept in every mode
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            dac_code_o <= `CODE_RESET;
        end else if (word_done_w) begin
            dac_code_o <= code_word_w;
        end
    end

    // Operating mode, changed only by a complete word
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            out_mode_o <= `MODE_RESET;
        end else if (word_done_w) begin
            out_mode_o <= mode_word_w;
        end
    end

    // Raw mode bits as they stood in the word
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            mode_bit_high_o <= 1'b0;
            mode_bit_low_o <= 1'b0;
        end else if (word_done_w) begin
            mode_bit_high_o <= mode_word_w[1];
            mode_bit_low_o <= mode_word_w[0];
        end
    end

    // Power-down flag for any mode but normal
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            powered_down_o <= 1'b0;
        end else if (word_done_w) begin
            powered_down_o <= is_powered_down(mode_word_w);
        end
    end

    // Zero and full scale flags follow the loaded code
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            code_zero_scale_o <= 1'b1;
            code_full_scale_o <= 1'b0;
        end else if (word_done_w) begin
            code_zero_scale_o <= code_word_w == `CODE_ZERO_SCALE;
            code_full_scale_o <= code_word_w == `CODE_FULL_SCALE;
        end
    end

    // Load pulse in the cycle the new code appears
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            load_pulse_o <= 1'b0;
        end else begin
            load_pulse_o <= word_done_w;
        end
    end

    // Abort pulse when select rises inside a word
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            abort_pulse_o <= 1'b0;
        end else begin
            abort_pulse_o <= is_shifting(state_reg) && sel_rise_w;
        end
    end
endmodule : serial_dac_word_loader
`default_nettype wire

// ---- serial_dac_word_loader_properties.sv ----
// Concurrent checks on the word loader outputs
`timescale 1ns/1ps
`default_nettype none
module serial_dac_word_loader_properties #(parameter int CODE_BITS = 10) (
    input wire logic clk_sys_i,
    input wire logic arst_n_i,
    input wire logic [CODE_BITS-1:0] dac_code_o,
    input wire logic [1:0] out_mode_o,
    input wire logic mode_bit_high_o,
    input wire logic mode_bit_low_o,
    input wire logic powered_down_o,
    input wire logic load_pulse_o,
    input wire logic abort_pulse_o,
    input wire logic code_zero_scale_o,
    input wire logic code_full_scale_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!arst_n_i);
    // Code and mode held two cycles, flags caught up
    sequence s_quiet;
        ($stable(dac_code_o) && $stable(out_mode_o)) [*2];
    endsequence
    property p_code; $changed(dac_code_o) |-> load_pulse_o; endproperty
    property p_mode; $changed(out_mode_o) |-> load_pulse_o; endproperty
    property p_abort;
        abort_pulse_o |-> !load_pulse_o && $stable({dac_code_o, out_mode_o});
    endproperty
    property p_abort_one; abort_pulse_o |=> !abort_pulse_o; endproperty
    property p_word;
        load_pulse_o |=> (!load_pulse_o && !abort_pulse_o) [*8];
    endproperty
    property p_scale; s_quiet |-> code_zero_scale_o == (dac_code_o == '0)
        && code_full_scale_o == (&dac_code_o); endproperty
    property p_flags; s_quiet |-> {mode_bit_high_o, mode_bit_low_o} ==
        out_mode_o && powered_down_o == (out_mode_o != 2'h0); endproperty
    property p_reset;
        !$past(arst_n_i) |-> dac_code_o == '0 && out_mode_o == 2'h0;
    endproperty
    a_code: assert property (p_code) else $error("code moved");
    a_mode: assert property (p_mode) else $error("mode moved");
    a_abort: assert property (p_abort) else $error("abort loaded");
    a_abort_one: assert property (p_abort_one) else $error("abort long");
    a_word: assert property (p_word) else $error("second load");
    a_scale: assert property (p_scale) else $error("scale flag");
    a_flags: assert property (p_flags) else $error("mode flag");
    a_reset: assert property (p_reset) else $error("reset value");
endmodule : serial_dac_word_loader_properties
bind serial_dac_word_loader serial_dac_word_loader_properties #(
    .CODE_BITS(CODE_BITS)) u_props (.clk_sys_i, .arst_n_i, .dac_code_o,
    .out_mode_o, .mode_bit_high_o, .mode_bit_low_o, .powered_down_o,
    .load_pulse_o, .abort_pulse_o, .code_zero_scale_o, .code_full_scale_o);
`default_nettype wire

// ---- dac_host_model.sv ----
// Host serial port model driving the loader pins
`timescale 1ns/1ps
`default_nettype none
module dac_host_model (
    output logic frame_sel_n_o,
    output logic shift_clk_o,
    output logic data_o
);
    // Idle: deselected, clock still
    initial begin
        frame_sel_n_o = 1'b1;
        shift_clk_o = 1'b0;
        data_o = 1'b0;
    end
    // One write of n clocks, half period h; under 16 aborts
    task automatic send(input logic [15:0] w, input int n, input int h);
        frame_sel_n_o = 1'b0;
        #(h);
        for (int i = 0; i < n; i++) begin
            shift_clk_o = 1'b1;
            data_o = (i < 16) ? w[15-i] : ~data_o;
            #(h);
            shift_clk_o = 1'b0;
            #(h);
        end
        frame_sel_n_o = 1'b1;
        data_o = ~data_o;
        #60;
    endtask : send
endmodule : dac_host_model
`default_nettype wire

// ---- test_serial_dac_word_loader.sv ----
// Self-checking bench for the word loader
`timescale 1ns/1ps
`default_nettype none
module test_serial_dac_word_loader;
    logic clk_sys_i = 1'b0;
    logic arst_n_i = 1'b0;
    wire sel_n, sclk, sdata;
    logic [9:0] code, exp_code = 10'h000;
    logic [1:0] mode, exp_mode = 2'h0;
    logic [15:0] w;
    wire [4:0] flags;
    wire load_p, abort_p;
    int loads = 0;
    int aborts = 0;
    int fail_count = 0;
    int cmp_count = 0;
    always #2.5 clk_sys_i = ~clk_sys_i;
    dac_host_model u_host (.frame_sel_n_o(sel_n), .shift_clk_o(sclk),
        .data_o(sdata));
    serial_dac_word_loader u_dut (.clk_sys_i, .arst_n_i,
        .frame_sel_n_i(sel_n), .shift_clk_i(sclk), .serial_data_i(sdata),
        .dac_code_o(code), .out_mode_o(mode), .mode_bit_high_o(flags[4]),
        .mode_bit_low_o(flags[3]), .powered_down_o(flags[2]),
        .load_pulse_o(load_p), .abort_pulse_o(abort_p),
        .code_zero_scale_o(flags[1]), .code_full_scale_o(flags[0]));
    // Converter field of a word
    function automatic logic [9:0] code_of(input logic [15:0] v);
        return v[11:2];
    endfunction : code_of
    // Status flags that the rules give for a code and mode
    function automatic logic [9:0] flags_of(input logic [9:0] c,
        input logic [1:0] m);
        return {5'h00, m, m != 2'h0, c == 10'h000, c == 10'h3ff};
    endfunction : flags_of
    // Counts of load and abort pulses, taken at each rising edge
    always @(posedge clk_sys_i) begin
        if (load_p === 1'b1) begin
            loads++;
        end
        if (abort_p === 1'b1) begin
            aborts++;
        end
    end
    task automatic check(input string what, input logic [9:0] e, g);
        cmp_count++;
        if (g !== e) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", what, e, g);
        end
    endtask : check
    task automatic check_count(input string what, input logic [7:0] e, g);
        cmp_count++;
        if (g !== e) begin
            fail_count++;
            $display("ERROR %s expected %0d seen %0d", what, e, g);
        end
    endtask : check_count
    // Send a word at a 48 ns link period, then compare
    task automatic word(input logic [15:0] v, input int n);
        int l0;
        int a0;
        @(posedge clk_sys_i);
        #1;
        l0 = loads;
        a0 = aborts;
        u_host.send(v, n, 24);
        if (n >= 16) begin
            exp_code = code_of(v);
            exp_mode = v[13:12];
        end
        check("code", exp_code, code);
        check("mode", {8'h00, exp_mode}, {8'h00, mode});
        check("flags", flags_of(exp_code, exp_mode), {5'h00, flags});
        check_count("loads", 8'(n >= 16), 8'(loads - l0));
        check_count("aborts", 8'(n < 16), 8'(aborts - a0));
    endtask : word
    task automatic results();
        $display("checks %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : results
    // Main sequence
    initial begin
        void'($urandom(32'h3b4c));
        repeat (3) @(posedge clk_sys_i);
        #1 arst_n_i = 1'b1;
        repeat (4) @(posedge clk_sys_i);
        check("reset code", 10'h000, code);
        check("reset flags", flags_of(10'h000, 2'h0), {5'h0, flags});
        $display("done reset");
        word(16'h0ffc, 16);
        word(16'hc000, 16);
        for (int m = 0; m < 4; m++) begin
            w = 16'($urandom);
            w[13:12] = 2'(m);
            word(w, 16);
        end
        $display("done modes");
        // Reset in mid-run returns code and mode to zero and leaves only the zero-scale flag set
        @(posedge clk_sys_i);
        #1 arst_n_i = 1'b0;
        repeat (3) @(posedge clk_sys_i);
        #1 arst_n_i = 1'b1;
        exp_code = 10'h000;
        exp_mode = 2'h0;
        repeat (4) @(posedge clk_sys_i);
        check("reset code", 10'h000, code);
        check("reset mode", {8'h00, exp_mode}, {8'h00, mode});
        check("reset flags", flags_of(10'h000, 2'h0), {5'h0, flags});
        $display("done mid reset");
        word(16'($urandom), 15);
        word(16'($urandom), 20);
        word(16'($urandom), 32);
        $display("done corners");
        repeat (20) word(16'($urandom), 12 + $urandom_range(8));
        $display("done random");
        results();
    end
    // Watchdog
    initial begin
        #400000;
        fail_count++;
        results();
    end
endmodule : test_serial_dac_word_loader
`default_nettype wire
